// >>> mft_consts.svh
`ifndef MFT_CONSTS_SVH
`define MFT_CONSTS_SVH
// register byte offsets
`define MFT_OFS_CTRL 8'h00
`define MFT_OFS_COUNT 8'h04
`define MFT_OFS_STAT 8'h08
`define MFT_OFS_CLR 8'h0c
`define MFT_OFS_IEN 8'h10
`define MFT_OFS_PWMHI 8'h14
`define MFT_OFS_RELOAD 8'h18
// control field positions
`define MFT_CTRL_MODE_LO 0
`define MFT_CTRL_MODE_HI 2
`define MFT_CTRL_START 3
`define MFT_CTRL_MSEL 4
`define MFT_CTRL_UP 5
`define MFT_CTRL_FREE 6
// counter values
`define MFT_ALL_ONES 16'hffff
`define MFT_ALL_ZERO 16'h0000
`define MFT_CNT_ONE 16'h0001
`define MFT_RST_CNT 16'h0000
`define MFT_RST_WORD 32'h0000_0000
`endif

// >>> mft_pkg.sv
package mft_pkg;
  typedef enum logic [2:0] {
    MFT_M_TIMER = 3'h0,
    MFT_M_EVENT = 3'h1,
    MFT_M_ONESHOT = 3'h2,
    MFT_M_PWM = 3'h3,
    MFT_M_MEAS = 3'h4
  } mft_mode_t;

  typedef struct packed {
    mft_mode_t mode;
    logic start;
    logic meas_sel;
    logic count_up;
    logic free_run;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic [15:0] pwm_hi;
    logic irq_st;
    logic irq_en;
    logic pulse_out;
    logic evt_d;
    logic first_done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } mft_state_t;
endpackage

// >>> mft_pulse_src.sv
`timescale 1ns/1ps
// external pulse source on the event pin: one rising edge per fire request,
// held several cycles so a synchronous edge detector cannot miss it
module mft_pulse_src #(
  parameter int HIGH_CYC = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_fire,
  output logic o_evt
);
  int cnt_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 0;
      o_evt <= 1'b0;
    end
    else if (i_fire)
    begin
      cnt_r <= HIGH_CYC;
      o_evt <= 1'b1;
    end
    else if (cnt_r > 1)
      cnt_r <= cnt_r - 1;
    else
    begin
      cnt_r <= 0;
      o_evt <= 1'b0;
    end
  end
endmodule // mft_pulse_src

// >>> mft_timer.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mft_consts.svh"
// How it works
// (R01) In timer mode a counter read returns the live count, or all ones when it lands on the reload instant.
// (R02) In event counter mode a read on the reload instant returns all ones after underflow and all zeros after overflow.
// (R03) Writing the count while halted loads the counter so a read before restart returns the written value.
// (R04) In one-shot mode clearing the start flag mid-count stops the counter and reloads it from the reload register.
// (R05) Aborting a one-shot count drives the timer output low.
// (R06) Aborting a one-shot count sets the interrupt request bit.
// (R07) Selecting one-shot mode after reset or from timer or event counter mode sets the interrupt request bit.
// (R08) Selecting PWM mode after reset or from timer or event counter mode sets the interrupt request bit.
// (R09) Clearing start during PWM stops counting and, if the output is high, drops it low and sets the request bit.
// (R10) If the PWM output is already low when stopped it stays low and no request is set.
// (R11) Changing the measurement select bit after a measurement starts sets the request bit.
// (R12) The first valid edge after a measurement starts loads an undefined value into reload with no request.
// (R13) Software rewrites the count after stopping a free-running event counter, before restarting it.
// (R14) Software clears the request bit after any mode change that sets it spuriously.
// (R15) The request bit stays set until software clears it and is set again by any new request condition.
module mft_timer (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_evt,
  output logic o_timer_a_pulse_out,
  output logic o_irq
);
  mft_pkg::mft_state_t s_r;
  mft_pkg::mft_state_t s_nxt;
  logic wr;
  logic rd;
  logic irq_set;
  logic reload_now;
  logic reload_zero;
  logic rise;
  logic fall;
  logic clr;
  mft_pkg::mft_mode_t new_mode;
  logic new_start;

  function automatic logic f_hit(input logic [7:0] a, input logic [7:0] o);
    f_hit = (a == o);
  endfunction

  function automatic logic f_mapped(input logic [7:0] a);
    f_mapped = f_hit(a, `MFT_OFS_CTRL) | f_hit(a, `MFT_OFS_COUNT) |
      f_hit(a, `MFT_OFS_STAT) | f_hit(a, `MFT_OFS_CLR) |
      f_hit(a, `MFT_OFS_IEN) | f_hit(a, `MFT_OFS_PWMHI) |
      f_hit(a, `MFT_OFS_RELOAD);
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    irq_set = 1'b0;
    reload_now = 1'b0;
    reload_zero = 1'b0;
    clr = 1'b0;
    // one wait state: read data is captured in the first access cycle, write data in the second
    rd = i_psel & i_penable & ~s_r.pready;
    wr = i_psel & i_penable & s_r.pready & i_pwrite;
    s_nxt.pready = rd;
    s_nxt.evt_d = i_evt;
    rise = i_evt & ~s_r.evt_d;
    fall = ~i_evt & s_r.evt_d;
    new_mode = mft_pkg::mft_mode_t'(
      i_pwdata[`MFT_CTRL_MODE_HI:`MFT_CTRL_MODE_LO]);
    new_start = i_pwdata[`MFT_CTRL_START];
    if (s_r.start)
    begin
      case (s_r.mode)
        mft_pkg::MFT_M_TIMER:
        begin
          if (s_r.cnt == `MFT_ALL_ZERO)
          begin
            s_nxt.cnt = s_r.reload;
            reload_now = 1'b1;
            irq_set = 1'b1;
          end
          else
            s_nxt.cnt = s_r.cnt - `MFT_CNT_ONE;
        end
        mft_pkg::MFT_M_EVENT:
        begin
          if (rise && s_r.count_up && s_r.cnt == `MFT_ALL_ONES)
          begin
            irq_set = 1'b1;
            reload_now = ~s_r.free_run;
            reload_zero = 1'b1;
            s_nxt.cnt = s_r.free_run ? `MFT_ALL_ZERO : s_r.reload;
          end
          else if (rise && !s_r.count_up && s_r.cnt == `MFT_ALL_ZERO)
          begin
            irq_set = 1'b1;
            reload_now = ~s_r.free_run;
            s_nxt.cnt = s_r.free_run ? `MFT_ALL_ONES : s_r.reload;
          end
          else if (rise)
            s_nxt.cnt = s_r.count_up ? s_r.cnt + `MFT_CNT_ONE :
              s_r.cnt - `MFT_CNT_ONE;
        end
        mft_pkg::MFT_M_ONESHOT:
        begin
          if (s_r.cnt == `MFT_ALL_ZERO)
          begin
            s_nxt.pulse_out = 1'b0;
            s_nxt.start = 1'b0;
            s_nxt.cnt = s_r.reload;
            irq_set = 1'b1;
          end
          else
          begin
            s_nxt.cnt = s_r.cnt - `MFT_CNT_ONE;
            s_nxt.pulse_out = 1'b1;
          end
        end
        mft_pkg::MFT_M_PWM:
        begin
          if (s_r.cnt == `MFT_ALL_ZERO)
          begin
            s_nxt.cnt = s_r.reload;
            irq_set = 1'b1;
          end
          else
            s_nxt.cnt = s_r.cnt - `MFT_CNT_ONE;
          // high for the last pwm_hi counts of each period
          s_nxt.pulse_out = (s_nxt.cnt < s_r.pwm_hi);
        end
        mft_pkg::MFT_M_MEAS:
        begin
          s_nxt.cnt = s_r.cnt + `MFT_CNT_ONE;
          // period uses rising edges only, width uses both
          if (rise || (s_r.meas_sel && fall))
          begin
            // (R12) first edge no request
            s_nxt.reload = s_r.cnt;
            s_nxt.cnt = `MFT_ALL_ZERO;
            s_nxt.first_done = 1'b1;
            irq_set = s_r.first_done;
          end
        end
        default:
          s_nxt.cnt = s_r.cnt;
      endcase
    end
    // software writes override the counting step above
    if (wr && f_hit(i_paddr, `MFT_OFS_CTRL))
    begin
      s_nxt.mode = new_mode;
      s_nxt.start = new_start;
      s_nxt.meas_sel = i_pwdata[`MFT_CTRL_MSEL];
      s_nxt.count_up = i_pwdata[`MFT_CTRL_UP];
      s_nxt.free_run = i_pwdata[`MFT_CTRL_FREE];
      // (R07) (R08) mode entry request
      if ((new_mode == mft_pkg::MFT_M_ONESHOT ||
           new_mode == mft_pkg::MFT_M_PWM) &&
          (s_r.mode == mft_pkg::MFT_M_TIMER ||
           s_r.mode == mft_pkg::MFT_M_EVENT))
        irq_set = 1'b1;
      // (R11) measurement select change
      if (s_r.mode == mft_pkg::MFT_M_MEAS && s_r.start &&
          i_pwdata[`MFT_CTRL_MSEL] != s_r.meas_sel)
        irq_set = 1'b1;
      if (s_r.start && !new_start)
      begin
        // (R04) (R05) (R06) one-shot abort
        if (s_r.mode == mft_pkg::MFT_M_ONESHOT)
        begin
          s_nxt.cnt = s_r.reload;
          s_nxt.pulse_out = 1'b0;
          irq_set = 1'b1;
        end
        // (R09) (R10) pwm stop
        if (s_r.mode == mft_pkg::MFT_M_PWM)
        begin
          irq_set = irq_set | s_r.pulse_out;
          s_nxt.pulse_out = 1'b0;
        end
      end
      if (!s_r.start && new_start)
      begin
        s_nxt.first_done = 1'b0;
        s_nxt.cnt = (new_mode == mft_pkg::MFT_M_MEAS) ? `MFT_ALL_ZERO :
          s_r.cnt;
        s_nxt.pulse_out = (new_mode == mft_pkg::MFT_M_ONESHOT);
      end
    end
    if (wr && f_hit(i_paddr, `MFT_OFS_COUNT))
    begin
      s_nxt.reload = i_pwdata[15:0];
      // (R03) halted write loads counter
      if (!s_r.start)
        s_nxt.cnt = i_pwdata[15:0];
    end
    if (wr && f_hit(i_paddr, `MFT_OFS_PWMHI))
      s_nxt.pwm_hi = i_pwdata[15:0];
    if (wr && f_hit(i_paddr, `MFT_OFS_IEN))
      s_nxt.irq_en = i_pwdata[0];
    clr = wr & f_hit(i_paddr, `MFT_OFS_CLR) & i_pwdata[0];
    // (R15) sticky, a new request beats the clear
    s_nxt.irq_st = (s_r.irq_st & ~clr) | irq_set;
    s_nxt.irq = s_nxt.irq_st & s_nxt.irq_en;
    if (rd)
    begin
      s_nxt.pslverr = ~f_mapped(i_paddr);
      s_nxt.prdata = `MFT_RST_WORD;
      if (f_hit(i_paddr, `MFT_OFS_CTRL))
      begin
        s_nxt.prdata[`MFT_CTRL_MODE_HI:`MFT_CTRL_MODE_LO] = s_r.mode;
        s_nxt.prdata[`MFT_CTRL_START] = s_r.start;
        s_nxt.prdata[`MFT_CTRL_MSEL] = s_r.meas_sel;
        s_nxt.prdata[`MFT_CTRL_UP] = s_r.count_up;
        s_nxt.prdata[`MFT_CTRL_FREE] = s_r.free_run;
      end
      // (R01) (R02) reload instant readback
      if (f_hit(i_paddr, `MFT_OFS_COUNT))
        s_nxt.prdata[15:0] = !reload_now ? s_r.cnt :
          (reload_zero ? `MFT_ALL_ZERO : `MFT_ALL_ONES);
      if (f_hit(i_paddr, `MFT_OFS_STAT))
        s_nxt.prdata[0] = s_r.irq_st;
      if (f_hit(i_paddr, `MFT_OFS_IEN))
        s_nxt.prdata[0] = s_r.irq_en;
      if (f_hit(i_paddr, `MFT_OFS_PWMHI))
        s_nxt.prdata[15:0] = s_r.pwm_hi;
      if (f_hit(i_paddr, `MFT_OFS_RELOAD))
        s_nxt.prdata[15:0] = s_r.reload;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // timer mode at reset, so first one-shot or pwm select requests
      s_r <= '0;
    end
    else
      s_r <= s_nxt;
  end

  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_timer_a_pulse_out = s_r.pulse_out;
  assign o_irq = s_r.irq;

  logic wr_ctrl;
  assign wr_ctrl = wr & f_hit(i_paddr, `MFT_OFS_CTRL);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  AST_TIMER_RELOAD_READ: assert property ( // (R01)
    rd && f_hit(i_paddr, `MFT_OFS_COUNT) && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_TIMER && s_r.cnt == `MFT_ALL_ZERO
    |=> o_prdata[15:0] == `MFT_ALL_ONES)
    else $error("timer reload read not all ones");
  AST_EVENT_OVF_READ: assert property ( // (R02)
    rd && f_hit(i_paddr, `MFT_OFS_COUNT) && s_r.start && rise &&
    s_r.mode == mft_pkg::MFT_M_EVENT && s_r.count_up && !s_r.free_run &&
    s_r.cnt == `MFT_ALL_ONES |=> o_prdata[15:0] == `MFT_ALL_ZERO)
    else $error("event overflow read not zero");
  AST_HALTED_WRITE: assert property ( // (R03)
    wr && f_hit(i_paddr, `MFT_OFS_COUNT) && !s_r.start
    |=> s_r.cnt == $past(i_pwdata[15:0]))
    else $error("halted count write lost");
  AST_ONESHOT_ABORT: assert property ( // (R04)
    wr_ctrl && !new_start && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_ONESHOT
    |=> !s_r.start && s_r.cnt == $past(s_r.reload))
    else $error("one-shot abort did not reload");
  AST_ONESHOT_OUT_LOW: assert property ( // (R05)
    wr_ctrl && !new_start && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_ONESHOT |=> !o_timer_a_pulse_out [*2])
    else $error("one-shot abort left output high");
  AST_ONESHOT_IRQ: assert property ( // (R06)
    wr_ctrl && !new_start && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_ONESHOT |=> s_r.irq_st)
    else $error("one-shot abort gave no request");
  AST_ONESHOT_ENTRY: assert property ( // (R07)
    wr_ctrl && new_mode == mft_pkg::MFT_M_ONESHOT &&
    s_r.mode == mft_pkg::MFT_M_TIMER |=> s_r.irq_st)
    else $error("one-shot entry gave no request");
  AST_PWM_ENTRY: assert property ( // (R08)
    wr_ctrl && new_mode == mft_pkg::MFT_M_PWM &&
    s_r.mode == mft_pkg::MFT_M_EVENT |=> s_r.irq_st)
    else $error("pwm entry gave no request");
  AST_PWM_STOP_HIGH: assert property ( // (R09)
    wr_ctrl && !new_start && s_r.start && o_timer_a_pulse_out &&
    s_r.mode == mft_pkg::MFT_M_PWM |=> !o_timer_a_pulse_out && s_r.irq_st)
    else $error("pwm stop from high mishandled");
  AST_PWM_STOP_LOW: assert property ( // (R10)
    wr_ctrl && !new_start && s_r.start && !o_timer_a_pulse_out &&
    !s_r.irq_st && s_r.mode == mft_pkg::MFT_M_PWM &&
    new_mode == mft_pkg::MFT_M_PWM |=> !o_timer_a_pulse_out && !s_r.irq_st)
    else $error("pwm stop from low raised request");
  AST_MSEL_CHANGE: assert property ( // (R11)
    wr_ctrl && s_r.start && s_r.mode == mft_pkg::MFT_M_MEAS &&
    i_pwdata[`MFT_CTRL_MSEL] != s_r.meas_sel |=> s_r.irq_st)
    else $error("select change gave no request");
  AST_FIRST_EDGE: assert property ( // (R12)
    s_r.start && s_r.mode == mft_pkg::MFT_M_MEAS && !s_r.first_done &&
    rise && !wr && !s_r.irq_st |=> !s_r.irq_st && s_r.first_done)
    else $error("first edge raised request");
  AST_STICKY: assert property ( // (R15)
    s_r.irq_st && !clr |=> s_r.irq_st ##1 (s_r.irq_st || $past(clr)))
    else $error("request bit dropped without clear");

  COV_ONESHOT_ABORT: cover property (wr_ctrl && !new_start && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_ONESHOT);
  COV_PWM_STOP: cover property (wr_ctrl && !new_start && s_r.start &&
    s_r.mode == mft_pkg::MFT_M_PWM);
  COV_MEAS_SECOND: cover property (s_r.first_done && irq_set &&
    s_r.mode == mft_pkg::MFT_M_MEAS);
  COV_IRQ_OUT: cover property (o_irq);
endmodule // mft_timer

// >>> mft_timer_tb.sv
`timescale 1ns/1ps
`include "mft_consts.svh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
  n_errors++; $display("CHECK FAILED t=%0t got %h want %h", $time, g, x); \
  end end
module mft_timer_tb;
  logic ref_clk, rst_n, psel, penable, pwrite, fire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, evt, pulse_out, irq, e, hi, seen_ones, seen_zero;
  int n_errors, samples_checked;

  always #12.5 ref_clk = ~ref_clk;

  mft_timer dut_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_evt(evt), .o_timer_a_pulse_out(pulse_out),
    .o_irq(irq));
  mft_pulse_src src_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
    .i_fire(fire), .o_evt(evt));

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic s,
    input logic ms);
    ctl = {27'h0, ms, s, m};
  endfunction

  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t no pready", $time);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic clr;
    wr(`MFT_OFS_CLR, 32'h0000_0001);
  endtask
  task automatic stat_is(input logic v);
    rd(`MFT_OFS_STAT);
    `CHK(q, {31'h0, v})
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse;
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fire = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(`MFT_OFS_IEN, 32'h0000_0001);
    wr(`MFT_OFS_CTRL, ctl(3'h2, 1'b0, 1'b0));
    stat_is(1'b1); // one-shot after reset
    `CHK(irq, 1'b1) // level follows status
    stat_is(1'b1); // still set
    wr(`MFT_OFS_IEN, 32'h0000_0000);
    idle(2);
    `CHK(irq, 1'b0) // masked
    wr(`MFT_OFS_IEN, 32'h0000_0001);
    clr(); // software clears
    stat_is(1'b0); // cleared by write
    `CHK(irq, 1'b0) // level drops
    for (int s = 0; s < 2; s++)
      for (int t = 2; t < 4; t++)
      begin
        wr(`MFT_OFS_CTRL, ctl(3'(s), 1'b0, 1'b0));
        clr(); // clear after switch
        stat_is(1'b0); // cleared
        wr(`MFT_OFS_CTRL, ctl(3'(t), 1'b0, 1'b0));
        stat_is(1'b1); // switch sets request
      end
    wr(`MFT_OFS_CTRL, ctl(3'h2, 1'b0, 1'b0));
    wr(`MFT_OFS_COUNT, 32'h0000_0100);
    clr();
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_0100) // written value
    wr(`MFT_OFS_CTRL, ctl(3'h2, 1'b1, 1'b0));
    idle(4);
    `CHK(pulse_out, 1'b1) // pulse running
    wr(`MFT_OFS_CTRL, ctl(3'h2, 1'b0, 1'b0));
    idle(2);
    `CHK(pulse_out, 1'b0) // abort drives low
    stat_is(1'b1); // abort request
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_0100) // reloaded
    for (int h = 0; h < 2; h++)
    begin
      hi = (h == 0);
      wr(`MFT_OFS_CTRL, ctl(3'h3, 1'b0, 1'b0));
      wr(`MFT_OFS_PWMHI, hi ? 32'h0000_ffff : 32'h0000_0000);
      wr(`MFT_OFS_COUNT, 32'h0000_0100);
      clr();
      wr(`MFT_OFS_CTRL, ctl(3'h3, 1'b1, 1'b0));
      idle(4);
      `CHK(pulse_out, hi) // level before stop
      wr(`MFT_OFS_CTRL, ctl(3'h3, 1'b0, 1'b0));
      idle(2);
      `CHK(pulse_out, 1'b0) // low after stop
      stat_is(hi); // request only if high
    end
    // read spacing of four cycles walks every phase of a five-cycle period
    wr(`MFT_OFS_CTRL, ctl(3'h0, 1'b0, 1'b0));
    wr(`MFT_OFS_COUNT, 32'h0000_0004);
    wr(`MFT_OFS_CTRL, ctl(3'h0, 1'b1, 1'b0));
    seen_ones = 1'b0;
    seen_zero = 1'b0;
    repeat (10)
    begin
      rd(`MFT_OFS_COUNT);
      if (q === 32'h0000_ffff)
        seen_ones = 1'b1;
      if (q === 32'h0000_0000)
        seen_zero = 1'b1;
    end
    `CHK(seen_ones, 1'b1) // all ones at reload
    `CHK(seen_zero, 1'b0) // zero never shown
    wr(`MFT_OFS_CTRL, ctl(3'h0, 1'b0, 1'b0));
    wr(`MFT_OFS_COUNT, 32'h0000_1234);
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_1234) // halted write
    wr(`MFT_OFS_CTRL, ctl(3'h4, 1'b1, 1'b0));
    clr();
    wr(`MFT_OFS_CTRL, ctl(3'h4, 1'b1, 1'b1));
    stat_is(1'b1); // select change
    wr(`MFT_OFS_CTRL, ctl(3'h4, 1'b0, 1'b0));
    wr(`MFT_OFS_CTRL, ctl(3'h4, 1'b1, 1'b0));
    clr();
    pulse();
    idle(6);
    stat_is(1'b0); // no request on first edge
    pulse();
    idle(6);
    stat_is(1'b1); // new edge sets request
    rd(`MFT_OFS_RELOAD);
    `CHK(q > 32'h0000_0008 && q < 32'h0000_0030, 1'b1) // later value
    // event counter: the read's first access cycle meets the edge
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b0, 1'b0) | 32'h0000_0020);
    wr(`MFT_OFS_COUNT, 32'h0000_ffff);
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b1, 1'b0) | 32'h0000_0020);
    fork
      pulse();
      rd(`MFT_OFS_COUNT);
    join
    `CHK(q, 32'h0000_0000) // overflow reads zero
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_ffff) // reloaded after overflow
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b0, 1'b0));
    wr(`MFT_OFS_COUNT, 32'h0000_0000);
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b1, 1'b0));
    fork
      pulse();
      rd(`MFT_OFS_COUNT);
    join
    `CHK(q, 32'h0000_ffff) // underflow reads all ones
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b0, 1'b0));
    wr(`MFT_OFS_COUNT, 32'h0000_0005);
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b1, 1'b0) | 32'h0000_0040);
    pulse();
    idle(4);
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_0004) // live count between edges
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b0, 1'b0) | 32'h0000_0040);
    wr(`MFT_OFS_COUNT, 32'h0000_0010); // rewrite before restart
    wr(`MFT_OFS_CTRL, ctl(3'h1, 1'b1, 1'b0) | 32'h0000_0040);
    rd(`MFT_OFS_COUNT);
    `CHK(q, 32'h0000_0010) // restart from rewritten value
    rd(8'h40);
    `CHK(e, 1'b1) // unmapped refused
    `CHK(q, 32'h0000_0000) // unmapped reads zero
    close_out();
  end
endmodule // mft_timer_tb
